// ===== logic/ipr5_pkg.sv
`default_nettype none
package ipr5_pkg;
  // ----------------------------------------
  // register map and field layout
  // ----------------------------------------
  localparam logic [3:0] ipr5_addr_prio = 4'h0;
  localparam int ipr5_t4_lsb = 12;
  localparam int ipr5_oc4_lsb = 8;
  localparam int ipr5_oc3_lsb = 4;
  localparam logic [2:0] ipr5_level_reset = 3'h4;
  localparam logic [2:0] ipr5_level_off = 3'h0;
  localparam logic [15:0] ipr5_impl_mask = 16'h7770;
endpackage : ipr5_pkg
`default_nettype wire

// ===== logic/ipr5_regs.sv
`default_nettype none
module ipr5_regs #(
  parameter int addr_width = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [addr_width-1:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  input wire logic timer_four_irq_req,
  input wire logic compare_ch_four_irq_req,
  input wire logic compare_ch_three_irq_req,
  output logic [2:0] timer_four_irq_level,
  output logic [2:0] compare_ch_four_irq_level,
  output logic [2:0] compare_ch_three_irq_level,
  output logic timer_four_irq_active,
  output logic compare_ch_four_irq_active,
  output logic compare_ch_three_irq_active
);
  initial begin
    if (addr_width < 4) begin
      $error("addr_width too small");
    end
  end

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic [2:0] t4;
    logic [2:0] oc4;
    logic [2:0] oc3;
    logic [15:0] rdata;
  } ipr5_state_type;

  ipr5_state_type st;
  ipr5_state_type next_st;

  function automatic logic [15:0] ipr5_pack(input logic [2:0] a, input logic [2:0] b,
                                            input logic [2:0] c);
    logic [15:0] v;
    v = 16'h0000;
    v[ipr5_pkg::ipr5_t4_lsb +: 3] = a;
    v[ipr5_pkg::ipr5_oc4_lsb +: 3] = b;
    v[ipr5_pkg::ipr5_oc3_lsb +: 3] = c;
    return v & ipr5_pkg::ipr5_impl_mask;
  endfunction : ipr5_pack

  wire logic hit = (addr == addr_width'(ipr5_pkg::ipr5_addr_prio));

  always_comb begin
    next_st = st;
    if (wr && hit) begin
      next_st.t4 = wdata[ipr5_pkg::ipr5_t4_lsb +: 3];
      next_st.oc4 = wdata[ipr5_pkg::ipr5_oc4_lsb +: 3];
      next_st.oc3 = wdata[ipr5_pkg::ipr5_oc3_lsb +: 3];
    end
    // read data stand only in the cycle after the strobe
    if (rd && hit) begin
      next_st.rdata = ipr5_pack(st.t4, st.oc4, st.oc3);
    end else begin
      next_st.rdata = 16'h0000;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st.t4 <= ipr5_pkg::ipr5_level_reset;
      st.oc4 <= ipr5_pkg::ipr5_level_reset;
      st.oc3 <= ipr5_pkg::ipr5_level_reset;
      st.rdata <= 16'h0000;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------
  // outputs to the arbiter
  // ----------------------------------------
  // level passes straight through: arbiter compares numerically, larger wins
  assign rdata = st.rdata;
  assign timer_four_irq_level = st.t4;
  assign compare_ch_four_irq_level = st.oc4;
  assign compare_ch_three_irq_level = st.oc3;
  assign timer_four_irq_active = timer_four_irq_req && (st.t4 != ipr5_pkg::ipr5_level_off);
  assign compare_ch_four_irq_active =
    compare_ch_four_irq_req && (st.oc4 != ipr5_pkg::ipr5_level_off);
  assign compare_ch_three_irq_active =
    compare_ch_three_irq_req && (st.oc3 != ipr5_pkg::ipr5_level_off);

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_t4_write: assert property (@(posedge clk) disable iff (rst)
    (wr && hit) |=> (timer_four_irq_level == $past(wdata[14:12])))
    else $error("timer four level not written");
  a_oc_write: assert property (@(posedge clk) disable iff (rst)
    (wr && hit) |=> (compare_ch_four_irq_level == $past(wdata[10:8]))
      && (compare_ch_three_irq_level == $past(wdata[6:4])))
    else $error("compare levels not written");
  a_hold_level: assert property (@(posedge clk) disable iff (rst)
    !(wr && hit) |=> $stable(timer_four_irq_level) && $stable(compare_ch_four_irq_level))
    else $error("level changed without write");
  a_off_masks: assert property (@(posedge clk) disable iff (rst)
    (compare_ch_three_irq_level == 3'h0) |-> !compare_ch_three_irq_active)
    else $error("disabled source presented");
  a_on_passes: assert property (@(posedge clk) disable iff (rst)
    (timer_four_irq_req && timer_four_irq_level != 3'h0) |-> timer_four_irq_active)
    else $error("enabled source dropped");
  a_unimpl_zero: assert property (@(posedge clk) disable iff (rst)
    (rd && hit) |=> ((rdata & 16'h888F) == 16'h0000)
      && (rdata[14:12] == $past(timer_four_irq_level)))
    else $error("bad read data");
  a_reset_val: assert property (@(posedge clk)
    $fell(rst) |-> (timer_four_irq_level == 3'h4) && (compare_ch_four_irq_level == 3'h4)
      && (compare_ch_three_irq_level == 3'h4))
    else $error("reset value wrong");
  a_rd_once: assert property (@(posedge clk) disable iff (rst)
    !(rd && hit) |=> (rdata == 16'h0000))
    else $error("read data outside read slot");

  c_write: cover property (@(posedge clk) disable iff (rst) wr && hit);
  c_read: cover property (@(posedge clk) disable iff (rst) rd && hit ##1 rd && hit);
  c_off: cover property (@(posedge clk) disable iff (rst)
    timer_four_irq_req && timer_four_irq_level == 3'h0);
endmodule : ipr5_regs
`default_nettype wire

// ===== verif/test_interrupt_priority_register_five.sv
`default_nettype none
module test_interrupt_priority_register_five;
  timeunit 1ns;
  timeprecision 1ns;
  // ---------------
  // stimulus, notes
  // ---------------
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, rd_d = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000, rdata, shadow = 16'h4440;
  logic [2:0] l4, lc4, lc3, act;
  logic [31:0] r;
  logic [27:0] q[$];
  int errors = 0, cmp_count = 0, seed = 32'hA60F0F88;
  // requests held high so the active outputs show the level gating alone
  ipr5_regs i_dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .timer_four_irq_req(1'b1), .compare_ch_four_irq_req(1'b1),
    .compare_ch_three_irq_req(1'b1), .timer_four_irq_level(l4),
    .compare_ch_four_irq_level(lc4), .compare_ch_three_irq_level(lc3),
    .timer_four_irq_active(act[2]), .compare_ch_four_irq_active(act[1]),
    .compare_ch_three_irq_active(act[0]));
  function automatic logic [27:0] ex(input logic [15:0] s, input logic m);
    return {|s[14:12], |s[10:8], |s[6:4], s[14:12], s[10:8], s[6:4], m ? s : 16'h0000};
  endfunction : ex
  task automatic put(input logic w, input logic rr, input logic [3:0] a, input logic [15:0] d);
    wr <= w;
    rd <= rr;
    addr <= a;
    wdata <= d;
    if (rr) q.push_back(ex(shadow, a == 4'h0));
    @(posedge clk);
    if (w && a == 4'h0) shadow = d & 16'h7770;
  endtask : put
  task automatic stop_test();
    if (errors == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : stop_test
  // read data stands one cycle after the strobe, so the note is taken then
  always @(posedge clk) begin
    rd_d <= rd;
    if (rd_d) begin
      cmp_count++;
      if ({act, l4, lc4, lc3, rdata} !== q[0]) begin
        errors++;
        $display("wrong value at %0t: got %h expected %h", $time,
          {act, l4, lc4, lc3, rdata}, q[0]);
      end
      void'(q.pop_front());
    end
  end
  initial forever #50 clk = ~clk;
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    put(1'b0, 1'b1, 4'h0, 16'h0000);
    put(1'b1, 1'b0, 4'h0, 16'hFFFF);
    put(1'b0, 1'b1, 4'h0, 16'h0000);
    for (int v = 0; v < 8; v++) begin
      put(1'b1, 1'b0, 4'h0, {1'b1, 3'(v), 1'b0, 3'(7 - v), 1'b1, 3'(v + 3), 4'hF});
      put(1'b0, 1'b1, 4'h0, 16'h0000);
    end
    put(1'b1, 1'b0, 4'h5, 16'h1230);
    put(1'b0, 1'b1, 4'h5, 16'h0000);
    put(1'b0, 1'b1, 4'h0, 16'h0000);
    repeat (24) begin
      r = $random(seed);
      put(r[4], !r[4], r[5] ? 4'h0 : r[9:6], r[31:16]);
    end
    put(1'b1, 1'b0, 4'h0, 16'h0000);
    rst <= 1'b1;
    shadow = 16'h4440;
    @(posedge clk);
    rst <= 1'b0;
    put(1'b0, 1'b1, 4'h0, 16'h0000);
    repeat (3) put(1'b0, 1'b0, 4'h0, 16'h0000);
    stop_test();
  end
  initial begin
    #200000;
    errors++;
    stop_test();
  end
endmodule : test_interrupt_priority_register_five
`default_nettype wire
